// [common/flash_pe_map.vh]
// Register indices, field positions, reset values and timing counts of the flash program/erase control
`ifndef FLASH_PE_MAP_VH
`define FLASH_PE_MAP_VH

// Register indices; byte address is four times the index, low 16 bits decoded
`define IDX_MODE_LOWER     32'hFFFFE800
`define IDX_MODE_UPPER     32'hFFFFE801
`define IDX_BLOCK_A        32'hFFFFE802
`define IDX_BLOCK_B        32'hFFFFE803
`define IDX_OVERLAY        32'hFFFFEC26

// Reset values
`define RST_MODE           8'h00
`define RST_BLOCK          8'h00
`define RST_OVERLAY        16'h0000
`define MODE_PIN_HIGH      8'h80

// Mode control field positions
`define BIT_PIN_LEVEL      7
`define BIT_FAULT          7
`define BIT_SW_PERMIT      6
`define BIT_ERASE_SETUP    5
`define BIT_PROG_SETUP     4
`define BIT_ERASE_VERIFY   3
`define BIT_PROG_VERIFY    2
`define BIT_ERASE_GO       1
`define BIT_PROG_GO        0

// Overlay control field positions
`define BIT_OVERLAY_SEL    3
`define OVL_BLOCK_HI       2
`define OVL_BLOCK_LO       0

// Block layout: seven 64 kB, one 32 kB, eight 4 kB
`define NUM_BLOCKS         16
`define NUM_BLOCKS_64K     7
`define NUM_BLOCKS_32K     1
`define NUM_BLOCKS_4K      8
`define BLOCK_4K_BITS      12
`define BLOCK_4K_BASE      19'h70000
`define LOWER_REGION_TOP   19'h3FFFF

// Access timing in cycles
`define WAIT_SHORT         3
`define WAIT_LONG          6

`endif

// [logic/overlay_read_mux.v]
// Read path of the flash array with RAM overlay of one 4 kB block
`timescale 1ns/1ps
`include "flash_pe_map.vh"

module overlay_read_mux #(
    parameter ADDR_W = 19,
    parameter DATA_W = 32
) (
    // Clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // Overlay setting
    input  wire              overlay_on,
    input  wire [2:0]        overlay_block,
    // Fetch request
    input  wire              fetch_valid,
    input  wire [ADDR_W-1:0] fetch_addr,
    input  wire [DATA_W-1:0] flash_rdata,
    input  wire [DATA_W-1:0] ram_rdata,
    // Result
    output reg  [DATA_W-1:0] fetch_rdata,
    output reg               fetch_from_ram
);

    wire [ADDR_W-1:0] block_base;
    wire              hit;

    assign block_base = `BLOCK_4K_BASE + {overlay_block, {`BLOCK_4K_BITS{1'b0}}};
    // With overlay released the fetch always reaches the array
    assign hit = overlay_on && (fetch_addr[ADDR_W-1:`BLOCK_4K_BITS] == block_base[ADDR_W-1:`BLOCK_4K_BITS]);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_rdata    <= {DATA_W{1'b0}};
            fetch_from_ram <= 1'b0;
        end else if (fetch_valid) begin
            fetch_rdata    <= hit ? ram_rdata : flash_rdata;
            fetch_from_ram <= hit;
        end
    end

endmodule // overlay_read_mux

// [logic/flash_program_erase_control.v]
// Flash program/erase mode control with APB register access and RAM overlay
`timescale 1ns/1ps
`include "flash_pe_map.vh"

module flash_program_erase_control #(
    parameter ADDR_W = 16,
    parameter FA_W   = 19
) (
    // APB clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    // Device pins and chip modes
    input  wire              hw_write_permit,
    input  wire              flash_on,
    input  wire              boot_mode,
    input  wire              hw_standby,
    input  wire              sw_standby,
    input  wire              flash_op_failed,
    // Boot serial path
    input  wire              serial_rx_line,
    output reg               serial_tx_line,
    input  wire              boot_tx,
    output reg               boot_rx,
    // Flash array control
    output reg  [3:0]        mode_lower,
    output reg  [3:0]        mode_upper,
    output reg  [`NUM_BLOCKS-1:0] erase_blocks,
    // Flash array fetch
    input  wire              fetch_valid,
    input  wire [FA_W-1:0]   fetch_addr,
    input  wire [31:0]       flash_rdata,
    input  wire [31:0]       ram_rdata,
    output wire [31:0]       fetch_rdata,
    output wire              fetch_from_ram
);

    // Full byte addresses; only the low ADDR_W bits reach the decoder
    localparam [33:0]       FULL_MODE_LOWER = {`IDX_MODE_LOWER, 2'b00};
    localparam [33:0]       FULL_MODE_UPPER = {`IDX_MODE_UPPER, 2'b00};
    localparam [33:0]       FULL_BLOCK_A    = {`IDX_BLOCK_A, 2'b00};
    localparam [33:0]       FULL_BLOCK_B    = {`IDX_BLOCK_B, 2'b00};
    localparam [33:0]       FULL_OVERLAY    = {`IDX_OVERLAY, 2'b00};
    localparam [31:0]       FULL_SHORT      = `WAIT_SHORT - 2;
    localparam [31:0]       FULL_LONG       = `WAIT_LONG - 2;
    localparam [7:0]        MODE_RST        = `RST_MODE;

    localparam [ADDR_W-1:0] A_MODE_LOWER = FULL_MODE_LOWER[ADDR_W-1:0];
    localparam [ADDR_W-1:0] A_MODE_UPPER = FULL_MODE_UPPER[ADDR_W-1:0];
    localparam [ADDR_W-1:0] A_BLOCK_A    = FULL_BLOCK_A[ADDR_W-1:0];
    localparam [ADDR_W-1:0] A_BLOCK_B    = FULL_BLOCK_B[ADDR_W-1:0];
    localparam [ADDR_W-1:0] A_OVERLAY    = FULL_OVERLAY[ADDR_W-1:0];
    localparam [2:0]        CNT_SHORT    = FULL_SHORT[2:0];
    localparam [2:0]        CNT_LONG     = FULL_LONG[2:0];

    // Stored bits 6..0 of each mode register; bit 7 is the pin or the fault flag
    reg  [6:0]  mode_bits [0:1];
    wire [13:0] next_mode;
    reg  [7:0]  block_a;
    reg  [7:0]  block_b;
    reg  [15:0] overlay_ctrl;
    reg         fault;
    reg  [2:0]  wait_cnt;

    wire        sel_lower;
    wire        sel_upper;
    wire        sel_a;
    wire        sel_b;
    wire        sel_ovl;
    wire        sel_ctrl;
    wire        mapped;
    wire        longword;
    wire        byte_only_ok;
    wire        bad_access;
    wire [2:0]  wait_need;
    wire        access;
    wire        wr_done;
    wire        wr_en;
    wire        standby;
    wire [7:0]  wbyte;
    reg  [31:0] next_rdata;

    assign sel_lower    = (paddr == A_MODE_LOWER);
    assign sel_upper    = (paddr == A_MODE_UPPER);
    assign sel_a        = (paddr == A_BLOCK_A);
    assign sel_b        = (paddr == A_BLOCK_B);
    assign sel_ovl      = (paddr == A_OVERLAY);
    assign sel_ctrl     = sel_lower | sel_upper | sel_a | sel_b;
    assign mapped       = sel_ctrl | sel_ovl;
    assign longword     = pwrite && (pstrb == 4'hF);
    // Control registers take only a byte write in lane 0
    assign byte_only_ok = !pwrite || (pstrb == 4'h1);
    assign bad_access   = !mapped || (sel_ctrl && !byte_only_ok) || (sel_ovl && pwrite && (pstrb == 4'h0));
    assign wait_need    = (sel_ovl && longword) ? CNT_LONG : CNT_SHORT;
    assign access       = psel && penable;
    assign pready       = access && (wait_cnt == wait_need);
    assign pslverr      = pready && bad_access;
    assign wr_done      = pready && pwrite && !bad_access;
    // Writes are void while the mode keeps the flash off
    assign wr_en        = wr_done && flash_on;
    assign standby      = hw_standby || sw_standby;
    assign wbyte        = pwdata[7:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 3'h0;
        end else if (access && !pready) begin
            wait_cnt <= wait_cnt + 3'h1;
        end else begin
            wait_cnt <= 3'h0;
        end
    end

    // Mode register write gating, one instance per region
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : region
            wire       hit;
            wire [6:0] cur;
            wire       permit_ok;
            wire       base_ok;
            reg  [6:0] next_bits;
            assign hit       = wr_en && (g == 0 ? sel_lower : sel_upper);
            assign cur       = mode_bits[g];
            assign permit_ok = hw_write_permit;
            assign base_ok   = hw_write_permit && cur[`BIT_SW_PERMIT];

            always @* begin
                next_bits = cur;
                if (hit) begin
                    if (permit_ok)
                        next_bits[`BIT_SW_PERMIT] = wbyte[`BIT_SW_PERMIT];
                    if (base_ok) begin
                        next_bits[`BIT_ERASE_SETUP]  = wbyte[`BIT_ERASE_SETUP];
                        next_bits[`BIT_PROG_SETUP]   = wbyte[`BIT_PROG_SETUP];
                        next_bits[`BIT_ERASE_VERIFY] = wbyte[`BIT_ERASE_VERIFY];
                        next_bits[`BIT_PROG_VERIFY]  = wbyte[`BIT_PROG_VERIFY];
                    end
                    // Go bits look at the setup bit already stored, so a joint write cannot arm them
                    if (base_ok && cur[`BIT_ERASE_SETUP])
                        next_bits[`BIT_ERASE_GO] = wbyte[`BIT_ERASE_GO];
                    if (base_ok && cur[`BIT_PROG_SETUP])
                        next_bits[`BIT_PROG_GO] = wbyte[`BIT_PROG_GO];
                end
                // Error protection drops both go bits
                if (fault) begin
                    next_bits[`BIT_ERASE_GO] = 1'b0;
                    next_bits[`BIT_PROG_GO]  = 1'b0;
                end
                if (!hw_write_permit)
                    next_bits = 7'h00;
            end

            assign next_mode[g*7 +: 7] = next_bits;
        end
    endgenerate

    // Both regions share one process so every stored bit has a single driver
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_bits[0] <= MODE_RST[6:0];
            mode_bits[1] <= MODE_RST[6:0];
        end else if (standby) begin
            mode_bits[0] <= MODE_RST[6:0];
            mode_bits[1] <= MODE_RST[6:0];
        end else begin
            mode_bits[0] <= next_mode[6:0];
            mode_bits[1] <= next_mode[13:7];
        end
    end

    // Erase block selection, each register cleared while its permit is absent
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_a <= `RST_BLOCK;
            block_b <= `RST_BLOCK;
        end else begin
            if (!hw_write_permit || !mode_bits[0][`BIT_SW_PERMIT] || standby)
                block_a <= `RST_BLOCK;
            else if (wr_en && sel_a)
                block_a <= wbyte;
            if (!hw_write_permit || !mode_bits[1][`BIT_SW_PERMIT] || standby) begin
                block_b <= `RST_BLOCK;
            end else if (wr_en && sel_b) begin
                // Low nibble belongs to the lower region, high nibble to the upper
                if (mode_bits[0][`BIT_SW_PERMIT])
                    block_b[3:0] <= wbyte[3:0];
                block_b[7:4] <= wbyte[7:4];
            end
        end
    end

    // Overlay control takes any byte lanes of its low halfword
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overlay_ctrl <= `RST_OVERLAY;
        end else if (wr_en && sel_ovl) begin
            if (pstrb[0])
                overlay_ctrl[7:0] <= pwdata[7:0];
            if (pstrb[1])
                overlay_ctrl[15:8] <= pwdata[15:8];
        end
    end

    // Only power-on reset and hardware standby clear the fault; a failure in that cycle still sets it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fault <= 1'b0;
        else if (flash_op_failed)
            fault <= 1'b1;
        else if (hw_standby)
            fault <= 1'b0;
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        if (flash_on) begin
            if (sel_lower)
                next_rdata[7:0] = {hw_write_permit, mode_bits[0]};
            else if (sel_upper)
                next_rdata[7:0] = {fault, mode_bits[1]};
            else if (sel_a)
                next_rdata[7:0] = block_a;
            else if (sel_b)
                next_rdata[7:0] = block_b;
            else if (sel_ovl)
                next_rdata[15:0] = overlay_ctrl;
        end
    end

    // Read data is captured during the access phase of a read and held until the next read transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (access && !pwrite)
            prdata <= next_rdata;
    end

    // Array control outputs: erase, program, erase-verify, program-verify per region
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_lower     <= 4'h0;
            mode_upper     <= 4'h0;
            erase_blocks   <= {`NUM_BLOCKS{1'b0}};
            serial_tx_line <= 1'b1;
            boot_rx        <= 1'b1;
        end else begin
            mode_lower <= {mode_bits[0][`BIT_ERASE_GO], mode_bits[0][`BIT_PROG_GO],
                           mode_bits[0][`BIT_ERASE_VERIFY], mode_bits[0][`BIT_PROG_VERIFY]};
            mode_upper <= {mode_bits[1][`BIT_ERASE_GO], mode_bits[1][`BIT_PROG_GO],
                           mode_bits[1][`BIT_ERASE_VERIFY], mode_bits[1][`BIT_PROG_VERIFY]};
            // Block bits 0..7 are the 4 kB blocks, 8 the 32 kB block, 9..15 the 64 kB blocks
            if (boot_mode)
                erase_blocks <= {`NUM_BLOCKS{1'b1}};
            else
                erase_blocks <= {block_b, block_a};
            // Serial lines are only routed to the loader in boot mode; idle level is high
            serial_tx_line <= boot_mode ? boot_tx : 1'b1;
            boot_rx        <= boot_mode ? serial_rx_line : 1'b1;
        end
    end

    overlay_read_mux #(
        .ADDR_W (FA_W),
        .DATA_W (32)
    ) u_overlay (
        .pclk           (pclk),
        .presetn        (presetn),
        .overlay_on     (overlay_ctrl[`BIT_OVERLAY_SEL]),
        .overlay_block  (overlay_ctrl[`OVL_BLOCK_HI:`OVL_BLOCK_LO]),
        .fetch_valid    (fetch_valid),
        .fetch_addr     (fetch_addr),
        .flash_rdata    (flash_rdata),
        .ram_rdata      (ram_rdata),
        .fetch_rdata    (fetch_rdata),
        .fetch_from_ram (fetch_from_ram)
    );

endmodule // flash_program_erase_control

// [tb/flash_pe_sva.sv]
// Port-level assertions for the flash program/erase control
`timescale 1ns/1ps
module flash_pe_sva #(
    parameter ADDR_W = 16
) (
    // Clock and reset
    input wire              pclk,
    input wire              presetn,
    // APB
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [3:0]        pstrb,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    // Pins and array control
    input wire              hw_write_permit,
    input wire              flash_on,
    input wire              boot_mode,
    input wire [3:0]        mode_lower,
    input wire [3:0]        mode_upper,
    input wire [15:0]       erase_blocks
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ctrl_setup;
        psel && !penable && paddr[15:4] == 12'hA00;
    endsequence
    sequence s_long_setup;
        psel && !penable && pwrite && paddr == 16'hB098 && pstrb == 4'hF;
    endsequence
    property p_short;
        s_ctrl_setup |=> !pready ##1 pready;
    endproperty
    a_short: assert property (p_short) else $error("control access not three cycles");
    property p_long;
        s_long_setup |=> !pready [*4] ##1 pready;
    endproperty
    a_long: assert property (p_long) else $error("overlay longword not six cycles");
    property p_byte_only;
        psel && penable && pready && pwrite && flash_on && paddr[15:4] == 12'hA00 |-> pslverr == (pstrb != 4'h1);
    endproperty
    a_byte_only: assert property (p_byte_only) else $error("control width error wrong");
    property p_off_zero;
        psel && penable && pready && !pwrite && !flash_on |=> prdata == 32'h0;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("disabled flash read not zero");
    property p_pin_bit;
        psel && penable && pready && !pwrite && flash_on && paddr == 16'hA000 |=> prdata[7] == $past(hw_write_permit);
    endproperty
    a_pin_bit: assert property (p_pin_bit) else $error("pin level bit wrong");
    property p_blk_clear;
        (!hw_write_permit && !boot_mode) [*2] |=> erase_blocks == 16'h0;
    endproperty
    a_blk_clear: assert property (p_blk_clear) else $error("block select kept with pin low");
    property p_mode_clear;
        !hw_write_permit [*2] |=> mode_lower == 4'h0 && mode_upper == 4'h0;
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("mode kept with pin low");
    property p_boot_all;
        boot_mode |=> erase_blocks == 16'hFFFF;
    endproperty
    a_boot_all: assert property (p_boot_all) else $error("boot erase not whole array");
endmodule // flash_pe_sva

bind flash_program_erase_control flash_pe_sva #(.ADDR_W(ADDR_W)) u_flash_pe_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_write_permit(hw_write_permit), .flash_on(flash_on), .boot_mode(boot_mode),
    .mode_lower(mode_lower), .mode_upper(mode_upper), .erase_blocks(erase_blocks)
);

// [tb/boot_host.sv]
// Behavioural host on the boot serial link
`timescale 1ns/1ps
module boot_host #(
    parameter BIT_CYC = 4
) (
    // Clock
    input wire       pclk,
    // Serial link
    input wire       tx_line_in,
    output reg       rx_line_out,
    // Last frame heard back
    output reg [9:0] echo
);
    integer j;
    initial rx_line_out = 1'b1;
    // Start bit, data LSB first, stop bit; line rests at mark level
    task send(input logic [7:0] b);
        integer i;
        logic [9:0] f;
        begin
            f = {1'b1, b, 1'b0};
            for (i = 0; i < 10; i++) begin
                rx_line_out <= f[i];
                repeat (BIT_CYC) @(posedge pclk);
            end
        end
    endtask
    // Sample mid-bit so a few cycles of path delay do not matter
    always begin
        @(negedge tx_line_in);
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (j = 0; j < 10; j++) begin
            echo[j] = tx_line_in;
            repeat (BIT_CYC) @(posedge pclk);
        end
    end
endmodule // boot_host

// [tb/tb.sv]
// Self-checking testbench of the flash program/erase control
`timescale 1ns/1ps
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [15:0] paddr = 0, erase_blocks;
    logic [31:0] pwdata = 0, prdata, rd, flash_rdata = 0, ram_rdata = 0, fetch_rdata;
    logic [3:0]  pstrb = 0, mode_lower, mode_upper;
    logic        hw_write_permit = 1, flash_on = 1, boot_mode = 0, hw_standby = 0, sw_standby = 0;
    logic        flash_op_failed = 0, serial_rx_line, serial_tx_line, boot_tx = 1, boot_rx;
    logic        fetch_valid = 0, fetch_from_ram, p;
    logic [18:0] fetch_addr = 0;
    logic [7:0]  m, d, x;
    logic [9:0]  echo;
    logic [15:0] ra [5] = '{16'hA000, 16'hA004, 16'hA008, 16'hA00C, 16'hB098};
    logic [31:0] rv [5] = '{32'h80, 32'h0, 32'h0, 32'h0, 32'h0};
    integer      n_errors = 0, total_checks = 0, cycles = 0, seed, i;

    flash_program_erase_control u_flash_program_erase_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_write_permit(hw_write_permit), .flash_on(flash_on),
        .boot_mode(boot_mode), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .flash_op_failed(flash_op_failed), .serial_rx_line(serial_rx_line),
        .serial_tx_line(serial_tx_line), .boot_tx(boot_tx), .boot_rx(boot_rx),
        .mode_lower(mode_lower), .mode_upper(mode_upper), .erase_blocks(erase_blocks),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .flash_rdata(flash_rdata),
        .ram_rdata(ram_rdata), .fetch_rdata(fetch_rdata), .fetch_from_ram(fetch_from_ram));
    boot_host u_boot_host (.pclk(pclk), .tx_line_in(serial_tx_line), .rx_line_out(serial_rx_line), .echo(echo));

    always #2.5 pclk = ~pclk;
    // On-chip serial unit stands in as a loopback
    always @(posedge pclk) boot_tx <= boot_rx;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end

    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] dat, input logic [3:0] s);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= dat;
            pstrb <= s;
            @(posedge pclk);
            penable <= 1'b1;
            // Only the bench timeout ends a wait that never sees pready
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task fet(input logic [18:0] a, input logic src);
        logic [31:0] r, f;
        begin
            r = $urandom;
            f = $urandom;
            ram_rdata <= r;
            flash_rdata <= f;
            fetch_addr <= a;
            fetch_valid <= 1'b1;
            @(posedge pclk);
            fetch_valid <= 1'b0;
            @(posedge pclk);
            chk(fetch_rdata, src ? r : f);
            chk({31'h0, fetch_from_ram}, {31'h0, src});
        end
    endtask
    // Gated update of the lower mode register after one write
    function logic [7:0] nxt(input logic [7:0] o, input logic [7:0] w, input logic pin);
        nxt = o;
        if (pin) begin
            nxt[6] = w[6];
            if (o[6]) nxt[5:2] = w[5:2];
            if (o[6] && o[5]) nxt[1] = w[1];
            if (o[6] && o[4]) nxt[0] = w[0];
        end else nxt = 8'h00;
        nxt[7] = pin;
    endfunction

    initial begin
        seed = $urandom(47393);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(0, ra[i], 0, 4'h0);
            chk(rd, rv[i]);
        end
        apb(0, 16'hA010, 0, 4'h0);
        chk({31'h0, er}, 32'h1);
        $display("reset values done");
        m = 8'h80;
        for (i = 0; i < 60; i++) begin
            p = ($urandom % 6) != 0;
            hw_write_permit <= p;
            if (!p) m = 8'h00;
            m[7] = p;
            d = $urandom;
            // Erase setup is only ever raised alone
            if (d[5] && !m[5]) d = {1'b0, m[6], 6'h20};
            apb(1, 16'hA000, {24'h0, d}, 4'h1);
            m = nxt(m, d, p);
            apb(0, 16'hA000, 0, 4'h0);
            chk(rd, {24'h0, m});
            chk({28'h0, mode_lower}, {28'h0, m[1], m[0], m[3], m[2]});
            x = $urandom;
            apb(1, 16'hA008, {24'h0, x}, 4'h1);
            apb(0, 16'hA008, 0, 4'h0);
            chk(rd, (p && m[6]) ? {24'h0, x} : 32'h0);
            chk({24'h0, erase_blocks[7:0]}, rd);
        end
        $display("mode gating done");
        // Standby leaves no go bit over from the random sequence
        hw_write_permit <= 1'b1;
        sw_standby <= 1'b1;
        @(posedge pclk);
        sw_standby <= 1'b0;
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'h80);
        apb(1, 16'hA000, 32'h40, 4'h1);
        apb(1, 16'hA000, 32'h60, 4'h1);
        apb(1, 16'hA000, 32'h62, 4'h1);
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'hE2);
        chk({28'h0, mode_lower}, 32'h8);
        apb(1, 16'hA000, 32'h40, 4'h1);
        apb(1, 16'hA000, 32'h50, 4'h1);
        apb(1, 16'hA000, 32'h51, 4'h1);
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'hD1);
        chk({28'h0, mode_lower}, 32'h4);
        apb(1, 16'hA000, 32'h40, 4'h1);
        apb(1, 16'hA000, 32'h48, 4'h1);
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'hC8);
        chk({28'h0, mode_lower}, 32'h2);
        apb(1, 16'hA004, 32'h40, 4'h1);
        apb(1, 16'hA004, 32'h60, 4'h1);
        apb(1, 16'hA004, 32'h62, 4'h1);
        apb(0, 16'hA004, 0, 4'h0);
        chk(rd, 32'h62);
        chk({28'h0, mode_upper}, 32'h8);
        flash_op_failed <= 1'b1;
        @(posedge pclk);
        flash_op_failed <= 1'b0;
        apb(0, 16'hA004, 0, 4'h0);
        chk(rd, 32'hE0);
        chk({28'h0, mode_upper}, 32'h0);
        $display("mode sequences done");
        apb(1, 16'hA000, 32'h40, 4'h1);
        apb(1, 16'hA004, 32'h40, 4'h1);
        apb(1, 16'hA00C, 32'hA5, 4'h1);
        apb(0, 16'hA00C, 0, 4'h0);
        chk(rd, 32'hA5);
        apb(1, 16'hA004, 32'h00, 4'h1);
        apb(0, 16'hA00C, 0, 4'h0);
        chk(rd, 32'h0);
        apb(1, 16'hA000, 32'h4000, 4'h2);
        chk({31'h0, er}, 32'h1);
        $display("block select done");
        // Loader data stays clear of the overlap RAM, so only fet drives ram_rdata
        apb(1, 16'hB098, 32'h0000000B, 4'h3);
        fet(19'h73010, 1'b1);
        fet(19'h74000, 1'b0);
        apb(1, 16'hB098, 32'h00000003, 4'hF);
        apb(0, 16'hB098, 0, 4'h0);
        chk(rd, 32'h3);
        fet(19'h73010, 1'b0);
        $display("overlay done");
        flash_op_failed <= 1'b1;
        @(posedge pclk);
        flash_op_failed <= 1'b0;
        apb(0, 16'hA004, 0, 4'h0);
        chk(rd, 32'h80);
        sw_standby <= 1'b1;
        @(posedge pclk);
        sw_standby <= 1'b0;
        apb(0, 16'hA004, 0, 4'h0);
        chk(rd, 32'h80);
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'h80);
        hw_standby <= 1'b1;
        @(posedge pclk);
        hw_standby <= 1'b0;
        apb(0, 16'hA004, 0, 4'h0);
        chk(rd, 32'h0);
        $display("fault and standby done");
        flash_on <= 1'b0;
        apb(1, 16'hA000, 32'h40, 4'h1);
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'h0);
        flash_on <= 1'b1;
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'h80);
        $display("flash off done");
        // Second reset with the pin low must leave the pin bit clear
        hw_write_permit <= 1'b0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 16'hA000, 0, 4'h0);
        chk(rd, 32'h0);
        chk({16'h0, erase_blocks}, 32'h0);
        hw_write_permit <= 1'b1;
        $display("second reset done");
        boot_mode <= 1'b1;
        @(posedge pclk);
        u_boot_host.send(8'hC5);
        repeat (8) @(posedge pclk);
        chk({22'h0, echo}, {22'h0, 1'b1, 8'hC5, 1'b0});
        chk({16'h0, erase_blocks}, 32'hFFFF);
        boot_mode <= 1'b0;
        $display("boot mode done");
        wrap_up;
    end
endmodule // tb
